// ===== core/gsr_control.sv
// Control logic of the grayscale reference generator: serial word and output routing
// Notes on behaviour
// - Select low: capture data on serial rising edge
// - Select high: serial edges leave register untouched
// - Words travel most significant bit first
// - Source select low: common follows reference input
// - Source select high: common to rail or ground
// - Route high buffers top; low ties to common
// - Power-down low floats all five level outputs
// - Both sleep selects high float middle three
// - Polarity picks positive or negative reference set
// - Sixteen bits: control, data, spare; load on rise
// - Short word clears shift register, changes nothing
`timescale 1ns/10ps

module gsr_control
	import gsr_pkg::*;
(
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	// Serial link pins
	input  wire logic                 i_select_load_n,
	input  wire logic                 i_serial_clk,
	input  wire logic                 i_serial_data,
	// Static control pins
	input  wire logic                 i_common_source_select,
	input  wire logic                 i_common_rail_select,
	input  wire logic                 i_top_output_route,
	input  wire logic                 i_global_power_down_n,
	input  wire logic                 i_sleep_select_a,
	input  wire logic                 i_sleep_select_b,
	input  wire logic                 i_polarity_select,
	// Converter register outputs
	output logic [CTRL_BITS-1:0]      o_ctrl_code,
	output logic [DATA_BITS-1:0]      o_dac_data,
	output logic                      o_word_load,
	// Common output switches
	output logic                      o_common_to_ref,
	output logic                      o_common_to_rail,
	output logic                      o_common_to_gnd,
	// Level output controls
	output logic [4:0]                o_level_oe,
	output logic                      o_top_buffer_en,
	output logic                      o_top_to_common,
	output logic                      o_level_pos_set
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic       cs_n_s;            // Synced select/load
	logic       sck_s;             // Synced serial clock
	logic       din_s;             // Synced serial data
	logic [6:0] pins_s;            // Synced static pins
	logic       cm_s;              // Common source select
	logic       rail_s;            // Common rail select
	logic       route_s;           // Top output route
	logic       pd_n_s;            // Global power-down, low active
	logic       sleep_a_s;         // Sleep select a
	logic       sleep_b_s;         // Sleep select b
	logic       pol_s;             // Polarity select

	// Link pins: select idles high, clock and data low
	gsr_sync #(.W(3), .RST_VAL(3'h4)) u_link_sync
	(
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async ({i_select_load_n, i_serial_clk, i_serial_data}),
		.o_sync  ({cs_n_s, sck_s, din_s})
	);

	// Static pins; power-down held asserted through reset
	gsr_sync #(.W(7), .RST_VAL(7'h00)) u_pin_sync
	(
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async ({i_common_source_select, i_common_rail_select, i_top_output_route,
		           i_global_power_down_n, i_sleep_select_a, i_sleep_select_b,
		           i_polarity_select}),
		.o_sync  (pins_s)
	);

	assign {cm_s, rail_s, route_s, pd_n_s, sleep_a_s, sleep_b_s, pol_s} = pins_s;

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	logic sck_q;                   // Serial clock one sample ago
	logic cs_q;                    // Select one sample ago
	logic sck_rise;                // Serial rising edge seen
	logic cs_rise;                 // Select rising edge seen

	// Clock and data share the same sync delay, so data is aligned to its edge
	assign sck_rise = sck_s & ~sck_q;
	assign cs_rise  = cs_n_s & ~cs_q;

	// ------------------------------------------------------------
	// Serial shift state
	// ------------------------------------------------------------
	logic [WORD_BITS-1:0] shreg;        // Input shift register
	logic [CNT_BITS-1:0]  bit_cnt;      // Rising edges in this frame
	logic [WORD_BITS-1:0] next_shreg;
	logic [CNT_BITS-1:0]  next_bit_cnt;
	logic [CTRL_BITS-1:0] next_ctrl_code;
	logic [DATA_BITS-1:0] next_dac_data;
	logic                 next_word_load;
	logic                 word_full;    // Sixteen edges seen

	assign word_full = (bit_cnt >= CNT_FULL);

	// Shift, count and load decisions
	always_comb
	begin
		next_shreg     = shreg;
		next_bit_cnt   = bit_cnt;
		next_ctrl_code = o_ctrl_code;
		next_dac_data  = o_dac_data;
		next_word_load = 1'b0;
		if (cs_rise)
		begin
			// End of frame
			if (word_full)
			begin
				// Complete word: apply control and data fields
				next_ctrl_code = shreg[CTRL_LSB +: CTRL_BITS];
				next_dac_data  = shreg[DATA_LSB +: DATA_BITS];
				next_word_load = 1'b1;
			end
			// Short or complete, the register starts clean
			next_shreg   = SHIFT_RST;
			next_bit_cnt = CNT_RST;
		end
		else if (!cs_n_s && sck_rise)
		begin
			// First bit ends up in the top position
			next_shreg = {shreg[WORD_BITS-2:0], din_s};
			if (!word_full)
			begin
				// Saturate at a full word
				next_bit_cnt = bit_cnt + 5'h01;
			end
		end
		// Select high with no rise: nothing shifts
	end

	// Register the serial state
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sck_q       <= 1'b0;
			cs_q        <= 1'b1;
			shreg       <= SHIFT_RST;
			bit_cnt     <= CNT_RST;
			o_ctrl_code <= CTRL_RST;
			o_dac_data  <= DATA_RST;
			o_word_load <= 1'b0;
		end
		else
		begin
			sck_q       <= sck_s;
			cs_q        <= cs_n_s;
			shreg       <= next_shreg;
			bit_cnt     <= next_bit_cnt;
			o_ctrl_code <= next_ctrl_code;
			o_dac_data  <= next_dac_data;
			o_word_load <= next_word_load;
		end
	end

	// ------------------------------------------------------------
	// Output routing
	// ------------------------------------------------------------
	logic       next_common_to_ref;
	logic       next_common_to_rail;
	logic       next_common_to_gnd;
	logic [4:0] next_level_oe;
	logic       next_top_buffer_en;
	logic       next_top_to_common;
	logic       next_level_pos_set;
	logic       mid_sleep;           // Both sleep selects high

	assign mid_sleep = sleep_a_s & sleep_b_s;

	// Switch and enable selection from the static pins
	always_comb
	begin
		// Common output source
		next_common_to_ref  = ~cm_s;
		next_common_to_rail = cm_s & rail_s;
		next_common_to_gnd  = cm_s & ~rail_s;
		// Top output: own buffer or tied to common
		next_top_buffer_en  = route_s;
		next_top_to_common  = ~route_s;
		// Level enables in normal operation
		next_level_oe       = {route_s, 3'h7, 1'b1};
		next_level_pos_set  = o_level_pos_set;
		if (mid_sleep)
		begin
			// Middle three float, bottom end still driven, top end per route
			next_level_oe[3:1] = 3'h0;
		end
		if (!pd_n_s)
		begin
			// Full shutdown: every level output floats
			next_level_oe      = OE_RST;
			next_top_buffer_en = 1'b0;
			next_top_to_common = 1'b0;
		end
		else
		begin
			// Reference set follows polarity outside power-down
			next_level_pos_set = pol_s;
		end
	end

	// Register the routing outputs
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_common_to_ref  <= 1'b0;
			o_common_to_rail <= 1'b0;
			o_common_to_gnd  <= 1'b0;
			o_level_oe       <= OE_RST;
			o_top_buffer_en  <= 1'b0;
			o_top_to_common  <= 1'b0;
			o_level_pos_set  <= 1'b0;
		end
		else
		begin
			o_common_to_ref  <= next_common_to_ref;
			o_common_to_rail <= next_common_to_rail;
			o_common_to_gnd  <= next_common_to_gnd;
			o_level_oe       <= next_level_oe;
			o_top_buffer_en  <= next_top_buffer_en;
			o_top_to_common  <= next_top_to_common;
			o_level_pos_set  <= next_level_pos_set;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_shift_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(sck_rise && !cs_n_s && !cs_rise) |=> (shreg[0] == $past(din_s)))
		else $error("serial bit not captured");

	chk_shift_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cs_n_s && !cs_rise) |=> $stable(shreg))
		else $error("shift register moved while select high");

	chk_msb_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cs_rise && word_full) |=> (o_ctrl_code == $past(shreg[15:12])))
		else $error("control code not taken from first bits");

	chk_common_ref: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!cm_s |=> (o_common_to_ref && !o_common_to_rail && !o_common_to_gnd))
		else $error("common not on reference input");

	chk_common_rail: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cm_s |=> (!o_common_to_ref && o_common_to_rail == $past(rail_s)
		          && o_common_to_gnd == !$past(rail_s)))
		else $error("common rail routing wrong");

	chk_top_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(pd_n_s && !route_s) |=> (!o_top_buffer_en && o_top_to_common && !o_level_oe[4]))
		else $error("top output not tied to common");

	chk_power_down: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!pd_n_s |=> (o_level_oe == 5'h00 && !o_top_to_common && !o_top_buffer_en))
		else $error("level output driven in power-down");

	chk_sleep_mid: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(pd_n_s && sleep_a_s && sleep_b_s) |=> (o_level_oe[3:1] == 3'h0 && o_level_oe[0]))
		else $error("sleep enables wrong");

	chk_polarity: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		pd_n_s |=> (o_level_pos_set == $past(pol_s)))
		else $error("polarity not followed");

	chk_word_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cs_rise && word_full) |=> (o_word_load && o_dac_data == $past(shreg[11:2]))
		##1 !o_word_load)
		else $error("full word not applied");

	chk_short_abort: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cs_rise && !word_full) |=> (!o_word_load && shreg == 16'h0000
		                             && $stable(o_ctrl_code) && $stable(o_dac_data)))
		else $error("short word changed state");

endmodule

// ===== core/gsr_pkg.sv
// Shared constants of the grayscale reference control logic
package gsr_pkg;

	// ------------------------------------------------------------
	// Clocking
	// ------------------------------------------------------------
	localparam int CLK_MHZ         = 40;                    // System clock rate
	localparam int SCK_MAX_MHZ     = 10;                    // Fastest serial clock
	localparam int CLK_PER_SCK_MIN = CLK_MHZ / SCK_MAX_MHZ; // Samples per serial period

	// ------------------------------------------------------------
	// Serial word layout
	// ------------------------------------------------------------
	localparam int WORD_BITS = 16;                   // Bits in one serial word
	localparam int CTRL_BITS = 4;                    // Control field width
	localparam int DATA_BITS = 10;                   // Data field width
	localparam int CTRL_LSB  = 12;                   // Control field position
	localparam int DATA_LSB  = 2;                    // Data field position
	localparam int CNT_BITS  = 5;                    // Edge counter width

	localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10; // Edges of a complete word

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [WORD_BITS-1:0] SHIFT_RST = 16'h0000; // Shift register
	localparam logic [CNT_BITS-1:0]  CNT_RST   = 5'h00;    // Edge counter
	localparam logic [CTRL_BITS-1:0] CTRL_RST  = 4'h0;     // Control code
	localparam logic [DATA_BITS-1:0] DATA_RST  = 10'h000;  // Converter data
	localparam logic [4:0]           OE_RST    = 5'h00;    // Level outputs floating

endpackage

// ===== core/gsr_sync.sv
// Two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/10ps

module gsr_sync
	import gsr_pkg::*;
#(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
)
(
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// Pin side
	input  wire logic [W-1:0] i_async,
	// Clock domain side
	output logic      [W-1:0] o_sync
);

	// ------------------------------------------------------------
	// Synchroniser stages
	// ------------------------------------------------------------
	logic [W-1:0] stage1;      // First stage, read only by o_sync

	// Two stages, constant reset value
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			stage1 <= RST_VAL;
			o_sync <= RST_VAL;
		end
		else
		begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end

endmodule

// ===== testbench/gsr_control_test.sv
// Self-checking bench of the grayscale reference control logic
`timescale 1ns/10ps

module gsr_control_test
	import gsr_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic                 clk, rst_n;
	logic                 sel_n, sck, sdi;
	logic                 css, rail, route, pdn, sla, slb, pol;
	logic [CTRL_BITS-1:0] ctrl;
	logic [DATA_BITS-1:0] data;
	logic                 load, to_ref, to_rail, to_gnd, top_en, top_com, pos;
	logic [4:0]           oe;
	int                   failures, num_checks, loads;
	logic                 last_pol;
	logic [WORD_BITS-1:0] w;

	gsr_host_model u_host (.i_clk(clk), .o_select_load_n(sel_n),
		.o_serial_clk(sck), .o_serial_data(sdi));

	gsr_control u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_select_load_n(sel_n),
		.i_serial_clk(sck), .i_serial_data(sdi), .i_common_source_select(css),
		.i_common_rail_select(rail), .i_top_output_route(route),
		.i_global_power_down_n(pdn), .i_sleep_select_a(sla), .i_sleep_select_b(slb),
		.i_polarity_select(pol), .o_ctrl_code(ctrl), .o_dac_data(data),
		.o_word_load(load), .o_common_to_ref(to_ref), .o_common_to_rail(to_rail),
		.o_common_to_gnd(to_gnd), .o_level_oe(oe), .o_top_buffer_en(top_en),
		.o_top_to_common(top_com), .o_level_pos_set(pos));

	// Clock at 40 MHz
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Count load pulses; a level held too long counts more than once
	always @(posedge clk)
		if (load === 1'b1)
			loads++;

	// Compare seen against expected
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	// Print counts and verdict, then stop
	task automatic end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Apply the static pins and check the routing four clocks on
	task automatic pins(input logic [6:0] v);
		logic sl;
		{css, rail, route, pdn, sla, slb, pol} = v;
		sl = sla & slb;
		if (pdn)
			last_pol = pol;
		repeat (4) @(negedge clk);
		check("to_ref", to_ref, !css);
		check("to_rail", to_rail, css & rail);
		check("to_gnd", to_gnd, css & !rail);
		check("oe", oe, pdn ? {route, !sl, !sl, !sl, 1'b1} : 5'h00);
		check("top_en", top_en, pdn & route);
		check("top_com", top_com, pdn & !route);
		check("pos", pos, last_pol);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		failures = 0;
		num_checks = 0;
		loads = 0;
		rst_n = 1'b0;
		{css, rail, route, pdn, sla, slb, pol} = 7'h13;
		last_pol = 1'b0;
		repeat (15) @(negedge clk);
		check("rst_oe", oe, OE_RST);
		check("rst_ctrl", ctrl, CTRL_RST);
		check("rst_data", data, DATA_RST);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		// Every control code, distinct data patterns
		for (int c = 0; c < 16; c++)
		begin
			w = {c[3:0], c[3:0], ~c[3:0], c[1:0], 2'h1};
			u_host.send(w, WORD_BITS);
			check("loads", 16'(loads), 16'(c + 1));
			check("ctrl", ctrl, w[15:12]);
			check("data", data, w[11:2]);
		end
		// Stray edges then a short frame: nothing may change
		u_host.stray(3);
		u_host.send(16'hFFFF, WORD_BITS - 1);
		check("short_loads", 16'(loads), 16'h0010);
		check("short_ctrl", ctrl, w[15:12]);
		check("short_data", data, w[11:2]);
		// A one-bit frame after the short one: the edge count must have restarted
		u_host.send(16'hFFFF, 1);
		check("restart_loads", 16'(loads), 16'h0010);
		w = 16'hA5C6;
		u_host.send(w, WORD_BITS);
		check("after_loads", 16'(loads), 16'h0011);
		check("after_ctrl", ctrl, w[15:12]);
		check("after_data", data, w[11:2]);
		// All static pin combinations
		for (int v = 0; v < 128; v++)
			pins(v[6:0]);
		end_of_test();
	end
endmodule

// ===== testbench/gsr_host_model.sv
// Host model that drives the three-wire write link
`timescale 1ns/10ps

module gsr_host_model
	import gsr_pkg::*;
(
	// Pacing clock
	input  wire logic i_clk,
	// Serial link pins
	output logic      o_select_load_n,
	output logic      o_serial_clk,
	output logic      o_serial_data
);
	// ------------------------------------------------------------
	// Idle levels: select high, serial clock parked low
	// ------------------------------------------------------------
	initial
	begin
		o_select_load_n = 1'b1;
		o_serial_clk    = 1'b0;
		o_serial_data   = 1'b0;
	end

	// Wait whole system clocks, moving only on falling edges
	task automatic hold(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	// Send the first n bits of a word; fewer than 16 aborts the frame
	task automatic send(input logic [WORD_BITS-1:0] word, input int n);
		o_select_load_n <= 1'b0;
		hold(4);
		for (int i = 0; i < n; i++)
		begin
			o_serial_data <= word[WORD_BITS-1-i];
			hold(4);
			o_serial_clk <= 1'b1;
			hold(4);
			o_serial_clk <= 1'b0;
		end
		hold(4);
		o_select_load_n <= 1'b1;
		o_serial_data   <= ~o_serial_data; // Released line shows no stale bit
		hold(8);
	endtask

	// Serial edges while the device is not selected
	task automatic stray(input int n);
		for (int i = 0; i < n; i++)
		begin
			o_serial_data <= ~o_serial_data;
			hold(4);
			o_serial_clk <= 1'b1;
			hold(4);
			o_serial_clk <= 1'b0;
		end
		hold(4);
	endtask
endmodule
